// [hw/ebc_pkg.sv]
// Shared types and constants for the external bus controller.
package ebc_pkg;

	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int NUM_WIN = 4;
	localparam int NUM_REGION = NUM_WIN + 1;
	localparam int HIT_W = 3;
	localparam int WIN_BASE_W = 12;
	localparam int SEG_FIRST = 16;
	localparam int SEG_TOP = 23;
	localparam int REF_HALF_DEF = 1;

	localparam logic [15:0] LANE8_MASK = 16'h00FF;
	localparam logic [15:0] LANE16_MASK = 16'hFFFF;
	localparam logic [23:0] LOW8_COVER = 24'h0000FF;
	localparam logic [23:0] LOW16_COVER = 24'h00FFFF;
	localparam logic [11:0] WIN_FULL_MASK = 12'hFFF;
	localparam logic [4:0] CS_NONE = 5'h1F;
	localparam logic [4:0] CS_ONE = 5'h01;
	localparam logic [23:0] ADDR_RST = 24'h000000;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [3:0] CNT_RST = 4'h0;

	typedef struct packed {
		logic enable;
		logic [11:0] base;
		logic [3:0] size;
	} window_address_select_t;

	typedef struct packed {
		logic [1:0] addr_cycles;
		logic [3:0] cmd_cycles;
		logic [1:0] recov_cycles;
	} region_timing_config_t;

	typedef struct packed {
		logic ready_en;
		logic ready_high;
		logic bus16;
		logic muxed;
		logic cs_en;
	} region_function_config_t;

	typedef struct packed {
		logic we;
		logic internal;
		logic [23:0] addr;
		logic [15:0] wdata;
	} access_t;

	typedef struct packed {
		logic sel;
		logic we;
		logic [23:0] addr;
		logic [15:0] wdata;
	} ipb_req_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ADDR = 2'h1,
		ST_CMD = 2'h3,
		ST_RECOV = 2'h2
	} bus_state_t;

endpackage : ebc_pkg

// [hw/window_address_decoder.sv]
// Priority decode of the four address windows.
`timescale 1ns/1ps
`default_nettype none

module window_address_decoder
(
	input wire logic [23:0] i_addr,
	input var ebc_pkg::window_address_select_t i_win [ebc_pkg::NUM_WIN],
	output logic [3:0] o_match,
	output logic [2:0] o_hit
);

	////////////////////////////////////////////////////////////////////////
	for (genvar w = 0; w < ebc_pkg::NUM_WIN; w++)
	begin : g_win
		logic [11:0] size_mask;
		assign size_mask = ebc_pkg::WIN_FULL_MASK << i_win[w].size;
		assign o_match[w] = i_win[w].enable &&
			(((i_addr[23:12] ^ i_win[w].base) & size_mask) == 12'h000);
	end

	// The highest numbered hit wins, so four beats three and two beats one.
	always_comb
	begin
		o_hit = 3'h0;
		for (int k = 0; k < ebc_pkg::NUM_WIN; k++)
		begin
			if (o_match[k])
			begin
				o_hit = 3'(k + 1);
			end
		end
	end

endmodule : window_address_decoder

`default_nettype wire

// [hw/external_bus_ctrl.sv]
// External bus controller: access sequencing, region timing and pin drive.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// How it works
// - Single-chip mode drives no pins but the reference clock out; external bus mode uses width and muxing.
// - Driven address bits are programmable from zero to twenty-four.
// - Data bus width is eight or sixteen bits per region.
// - Multiplexed regions share address and data lines; demultiplexed do not.
// - Demultiplexed regions drive low address bits on dedicated lines.
// - Active segment lines are selectable; unused lines stay released.
// - One chip select per window plus default; only the hit one asserts.
// - Each region has its own timing and function configuration.
// - A ready input with selectable polarity stretches accesses.
// - Up to four address windows, each with its own bus characteristics.
// - Window four beats three, window two beats one when overlapping.
// - Addresses outside all windows use the default region configuration.
// - Bus timing after the start of an access follows the rising edge of the reference clock out.
// - Bus mode is switched per access by the window that is hit.
// - Internal peripheral bus accesses run the same sequence as external ones.
////////////////////////////////////////////////////////////////////////////

module external_bus_ctrl
#(
	parameter int REF_HALF = ebc_pkg::REF_HALF_DEF
)
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_single_chip,
	input wire logic [4:0] i_addr_width,
	input wire logic [2:0] i_seg_lines,
	input var ebc_pkg::window_address_select_t i_window_address_select [ebc_pkg::NUM_WIN],
	input var ebc_pkg::region_timing_config_t i_region_timing_config [ebc_pkg::NUM_WIN],
	input var ebc_pkg::region_function_config_t i_region_function_config [ebc_pkg::NUM_WIN],
	input var ebc_pkg::region_timing_config_t i_default_region_timing_config,
	input var ebc_pkg::region_function_config_t i_default_region_function_config,
	input wire logic i_req,
	input var ebc_pkg::access_t i_access,
	output logic o_busy,
	output logic o_ack,
	output logic o_err,
	output logic [15:0] o_rdata,
	output logic o_bus_reference_clock_out,
	output logic o_ale,
	output logic o_rd_b,
	output logic o_wr_b,
	output logic [4:0] o_cs_b,
	output logic [23:0] o_addr,
	output logic [23:0] o_addr_oe,
	output logic [15:0] o_ad,
	output logic [15:0] o_ad_oe,
	input wire logic [15:0] i_ad,
	input wire logic i_ready,
	output var ebc_pkg::ipb_req_t o_internal_peripheral_bus,
	input wire logic [15:0] i_internal_peripheral_bus_rdata,
	input wire logic i_internal_peripheral_bus_ready
);

	logic rst_meta;
	logic rst_n;
	logic ready_meta;
	logic ready_sync;
	logic [15:0] ad_meta;
	logic [15:0] ad_sync;
	logic [7:0] div_cnt;
	logic [7:0] next_div_cnt;
	logic next_ref;
	logic ref_rise;
	ebc_pkg::bus_state_t state;
	ebc_pkg::bus_state_t next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	ebc_pkg::access_t cur;
	ebc_pkg::access_t next_cur;
	ebc_pkg::region_timing_config_t cur_t;
	ebc_pkg::region_timing_config_t next_cur_t;
	ebc_pkg::region_function_config_t cur_f;
	ebc_pkg::region_function_config_t next_cur_f;
	logic [2:0] cur_hit;
	logic [2:0] next_cur_hit;
	logic [4:0] cur_width;
	logic [4:0] next_cur_width;
	logic next_busy;
	logic next_ack;
	logic next_err;
	logic [15:0] next_rdata;
	logic next_ale;
	logic next_rd_b;
	logic next_wr_b;
	logic [4:0] next_cs_b;
	logic [23:0] next_addr;
	logic [23:0] next_addr_oe;
	logic [15:0] next_ad;
	logic [15:0] next_ad_oe;
	ebc_pkg::ipb_req_t next_ipb;
	logic [3:0] dec_match;
	logic [2:0] dec_hit;
	ebc_pkg::region_timing_config_t all_t [ebc_pkg::NUM_REGION];
	ebc_pkg::region_function_config_t all_f [ebc_pkg::NUM_REGION];
	ebc_pkg::region_timing_config_t sel_t;
	ebc_pkg::region_function_config_t sel_f;
	logic [23:0] drive_mask;
	logic [15:0] cur_lane;
	logic ready_ok;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Read data passes two flops, so it must be stable two clocks early.
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ready_meta <= 1'b0;
			ready_sync <= 1'b0;
			ad_meta <= ebc_pkg::DATA_RST;
			ad_sync <= ebc_pkg::DATA_RST;
		end
		else
		begin
			ready_meta <= i_ready;
			ready_sync <= ready_meta;
			ad_meta <= i_ad;
			ad_sync <= ad_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reference clock divider; all phase changes but the start from idle coincide with its rise.
	always_comb
	begin
		ref_rise = (div_cnt == 8'(REF_HALF - 1)) && !o_bus_reference_clock_out;
		next_div_cnt = div_cnt + 8'h01;
		next_ref = o_bus_reference_clock_out;
		if (div_cnt == 8'(REF_HALF - 1))
		begin
			next_div_cnt = 8'h00;
			next_ref = !o_bus_reference_clock_out;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt <= 8'h00;
			o_bus_reference_clock_out <= 1'b0;
		end
		else
		begin
			div_cnt <= next_div_cnt;
			o_bus_reference_clock_out <= next_ref;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Region selection.
	window_address_decoder u_dec
	(
		.i_addr(i_access.addr),
		.i_win(i_window_address_select),
		.o_match(dec_match),
		.o_hit(dec_hit)
	);

	always_comb
	begin
		all_t[0] = i_default_region_timing_config;
		all_f[0] = i_default_region_function_config;
		for (int k = 0; k < ebc_pkg::NUM_WIN; k++)
		begin
			all_t[k + 1] = i_region_timing_config[k];
			all_f[k + 1] = i_region_function_config[k];
		end
		sel_t = all_t[dec_hit];
		sel_f = all_f[dec_hit];
	end

	// Segment lines above the selected count are left free for other use.
	for (genvar i = 0; i < ebc_pkg::ADDR_W; i++)
	begin : g_mask
		if (i < ebc_pkg::SEG_FIRST || i >= ebc_pkg::SEG_TOP)
		begin : g_plain
			assign drive_mask[i] = 5'(i) < i_addr_width;
		end
		else
		begin : g_seg
			assign drive_mask[i] = (5'(i) < i_addr_width) &&
				(3'(i - ebc_pkg::SEG_FIRST) < i_seg_lines);
		end
	end

	assign cur_lane = cur_f.bus16 ? ebc_pkg::LANE16_MASK : ebc_pkg::LANE8_MASK;
	assign ready_ok = cur.internal ? i_internal_peripheral_bus_ready :
		(!cur_f.ready_en || (ready_sync == cur_f.ready_high));

	////////////////////////////////////////////////////////////////////////
	// Access sequencer.
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_cur = cur;
		next_cur_t = cur_t;
		next_cur_f = cur_f;
		next_cur_hit = cur_hit;
		next_cur_width = cur_width;
		next_busy = o_busy;
		next_ack = 1'b0;
		next_err = 1'b0;
		next_rdata = o_rdata;
		next_ale = o_ale;
		next_rd_b = o_rd_b;
		next_wr_b = o_wr_b;
		next_cs_b = o_cs_b;
		next_addr = o_addr;
		next_addr_oe = o_addr_oe;
		next_ad = o_ad;
		next_ad_oe = o_ad_oe;
		next_ipb = o_internal_peripheral_bus;
		case (state)
			ebc_pkg::ST_IDLE:
			begin
				if (i_req && !i_access.internal && i_single_chip)
				begin
					next_ack = 1'b1;
					next_err = 1'b1;
				end
				else if (i_req)
				begin
					next_state = ebc_pkg::ST_ADDR;
					next_busy = 1'b1;
					next_cur = i_access;
					next_cur_t = sel_t;
					next_cur_f = sel_f;
					next_cur_hit = dec_hit;
					next_cur_width = i_addr_width;
					next_cnt = {2'b00, sel_t.addr_cycles};
					if (i_access.internal)
					begin
						next_ipb = {1'b1, i_access.we, i_access.addr,
							i_access.wdata};
					end
					else
					begin
						next_ale = 1'b1;
						next_addr = i_access.addr;
						next_addr_oe = sel_f.muxed ? drive_mask & ~(sel_f.bus16 ?
							ebc_pkg::LOW16_COVER : ebc_pkg::LOW8_COVER) :
							drive_mask;
						next_ad = sel_f.muxed ? i_access.addr[15:0] &
							drive_mask[15:0] : ebc_pkg::DATA_RST;
						next_ad_oe = sel_f.muxed ? drive_mask[15:0] &
							(sel_f.bus16 ? ebc_pkg::LANE16_MASK :
							ebc_pkg::LANE8_MASK) : ebc_pkg::DATA_RST;
						next_cs_b = sel_f.cs_en ? ~(ebc_pkg::CS_ONE << dec_hit) :
							ebc_pkg::CS_NONE;
					end
				end
			end
			ebc_pkg::ST_ADDR:
			begin
				if (ref_rise && cnt != ebc_pkg::CNT_RST)
				begin
					next_cnt = cnt - 4'h1;
				end
				else if (ref_rise)
				begin
					next_state = ebc_pkg::ST_CMD;
					next_cnt = cur_t.cmd_cycles;
					next_ale = 1'b0;
					if (!cur.internal)
					begin
						next_rd_b = cur.we;
						next_wr_b = !cur.we;
						next_ad = cur.wdata & cur_lane;
						next_ad_oe = cur.we ? cur_lane : ebc_pkg::DATA_RST;
					end
				end
			end
			ebc_pkg::ST_CMD:
			begin
				if (ref_rise && cnt != ebc_pkg::CNT_RST)
				begin
					next_cnt = cnt - 4'h1;
				end
				else if (ref_rise && ready_ok)
				begin
					next_state = ebc_pkg::ST_RECOV;
					next_cnt = {2'b00, cur_t.recov_cycles};
					next_rd_b = 1'b1;
					next_wr_b = 1'b1;
					next_ipb.sel = 1'b0;
					next_rdata = cur.internal ? i_internal_peripheral_bus_rdata :
						ad_sync & cur_lane;
				end
			end
			ebc_pkg::ST_RECOV:
			begin
				if (ref_rise && cnt != ebc_pkg::CNT_RST)
				begin
					next_cnt = cnt - 4'h1;
				end
				else if (ref_rise)
				begin
					next_state = ebc_pkg::ST_IDLE;
					next_busy = 1'b0;
					next_ack = 1'b1;
					next_cs_b = ebc_pkg::CS_NONE;
					next_addr_oe = ebc_pkg::ADDR_RST;
					next_ad_oe = ebc_pkg::DATA_RST;
				end
			end
			default:
			begin
				next_state = ebc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ebc_pkg::ST_IDLE;
			cnt <= ebc_pkg::CNT_RST;
			cur <= '0;
			cur_t <= '0;
			cur_f <= '0;
			cur_hit <= 3'h0;
			cur_width <= 5'h00;
			o_busy <= 1'b0;
			o_ack <= 1'b0;
			o_err <= 1'b0;
			o_rdata <= ebc_pkg::DATA_RST;
			o_ale <= 1'b0;
			o_rd_b <= 1'b1;
			o_wr_b <= 1'b1;
			o_cs_b <= ebc_pkg::CS_NONE;
			o_addr <= ebc_pkg::ADDR_RST;
			o_addr_oe <= ebc_pkg::ADDR_RST;
			o_ad <= ebc_pkg::DATA_RST;
			o_ad_oe <= ebc_pkg::DATA_RST;
			o_internal_peripheral_bus <= '0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			cur <= next_cur;
			cur_t <= next_cur_t;
			cur_f <= next_cur_f;
			cur_hit <= next_cur_hit;
			cur_width <= next_cur_width;
			o_busy <= next_busy;
			o_ack <= next_ack;
			o_err <= next_err;
			o_rdata <= next_rdata;
			o_ale <= next_ale;
			o_rd_b <= next_rd_b;
			o_wr_b <= next_wr_b;
			o_cs_b <= next_cs_b;
			o_addr <= next_addr;
			o_addr_oe <= next_addr_oe;
			o_ad <= next_ad;
			o_ad_oe <= next_ad_oe;
			o_internal_peripheral_bus <= next_ipb;
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_SINGLE_CHIP: assert property ((state == ebc_pkg::ST_IDLE && i_single_chip)
		|=> (o_addr_oe == 24'h000000 && o_ad_oe == 16'h0000))
		else $error("pins driven in single-chip mode");
	AST_ADDR_WIDTH: assert property ((state != ebc_pkg::ST_IDLE && !cur.internal)
		|-> $countones(o_addr_oe) <= int'(cur_width))
		else $error("more address bits driven than programmed");
	AST_LANE8: assert property ((state != ebc_pkg::ST_IDLE && !cur_f.bus16)
		|-> o_ad_oe[15:8] == 8'h00)
		else $error("upper data lane driven on byte bus");
	AST_MUX_SHARED: assert property ((state == ebc_pkg::ST_ADDR && cur_f.muxed &&
		!cur.internal) |-> (o_ale && o_addr_oe[7:0] == 8'h00))
		else $error("muxed address not on shared lines");
	AST_DEMUX_LOW: assert property ((state == ebc_pkg::ST_CMD && !cur_f.muxed &&
		!cur.internal && cur_width >= 5'h08) |-> o_addr_oe[7:0] == 8'hFF)
		else $error("demuxed low address not driven");
	AST_CS_ONE: assert property ($onehot0(~o_cs_b))
		else $error("more than one chip select active");
	AST_CS_HIT: assert property ((state != ebc_pkg::ST_IDLE && !cur.internal &&
		cur_f.cs_en) |-> !o_cs_b[cur_hit])
		else $error("chip select of hit region not active");
	AST_PRIO_HIGH: assert property ((dec_match[3] && dec_match[2])
		|-> dec_hit == 3'h4)
		else $error("window four did not beat window three");
	AST_DEFAULT: assert property ((dec_match == 4'h0) |-> dec_hit == 3'h0)
		else $error("no window hit but default not chosen");
	// The take from idle follows the request, not the reference clock.
	AST_REF_EDGE: assert property ((state != ebc_pkg::ST_IDLE &&
		$past(state) != ebc_pkg::ST_IDLE && $changed(state))
		|-> $rose(o_bus_reference_clock_out))
		else $error("bus phase changed off reference rising edge");
	AST_MODE_PER_ACCESS: assert property ((state == ebc_pkg::ST_IDLE && i_req &&
		(i_access.internal || !i_single_chip)) |=> cur_f == $past(sel_f))
		else $error("access did not take its region mode");
	AST_READY_HOLD: assert property ((state == ebc_pkg::ST_CMD && ref_rise &&
		cnt == 4'h0 && !ready_ok) |=> (state == ebc_pkg::ST_CMD && !o_ack))
		else $error("command phase ended without ready");

endmodule : external_bus_ctrl

`default_nettype wire

// [verif/ext_mem_model.sv]
// Behavioural external memory on the parallel bus with a ready wait.
`timescale 1ns/1ps
`default_nettype none

module ext_mem_model
(
	input wire logic i_clk,
	input wire logic i_ale,
	input wire logic i_rd_b,
	input wire logic i_wr_b,
	input wire logic [4:0] i_cs_b,
	input wire logic [23:0] i_addr,
	input wire logic [15:0] i_ad,
	input wire logic i_muxed,
	input wire logic i_ready_high,
	input wire logic [7:0] i_wait,
	output logic [15:0] o_ad,
	output logic o_ready
);
	logic [15:0] mem [256];
	logic [7:0] adr;
	logic [7:0] cnt;
	logic [15:0] last = 16'h0000;
	logic sel;

	assign sel = (i_cs_b != 5'h1F);

	always @(posedge i_clk)
	begin
		if (i_ale)
			adr <= i_muxed ? i_ad[7:0] : i_addr[7:0];
		if (sel && !i_wr_b)
			mem[adr] <= i_ad;
		cnt <= (sel && !(i_rd_b && i_wr_b)) ? cnt + 8'h01 : 8'h00;
		last <= o_ad;
	end

	// A released bus toggles, so stale data can never pass for a read.
	assign o_ad = (sel && !i_rd_b) ? mem[adr] : ~last;
	// Ready is withheld for i_wait cycles of strobe.
	assign o_ready = (sel && cnt >= i_wait) ? i_ready_high : ~i_ready_high;
endmodule : ext_mem_model

`default_nettype wire

// [verif/tb_top.sv]
// Self-checking testbench of the external bus controller.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam int RH = 2;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic single_chip = 1'b0;
	logic [4:0] aw = 5'h18;
	logic [2:0] seg = 3'h7;
	ebc_pkg::window_address_select_t win [ebc_pkg::NUM_WIN];
	ebc_pkg::region_timing_config_t tcfg [ebc_pkg::NUM_WIN];
	ebc_pkg::region_function_config_t fcfg [ebc_pkg::NUM_WIN];
	ebc_pkg::region_timing_config_t dtcfg = 8'h00;
	ebc_pkg::region_function_config_t dfcfg = 5'h0D;
	logic req = 1'b0;
	ebc_pkg::access_t acc = '0;
	logic busy, ack, err, refclk, ale, rd_b, wr_b, mrdy;
	logic [4:0] cs_b, s_cs;
	logic [15:0] rdata, ad, ad_oe, mem_ad, bus_in, s_ad, s_rd;
	logic [23:0] addr, addr_oe, s_addr, s_oe;
	ebc_pkg::ipb_req_t ipb;
	logic ipb_rdy = 1'b0;
	logic muxed = 1'b0;
	logic rhigh = 1'b1;
	logic s_err, s_busy;
	logic [7:0] wt = 8'h00;
	int fails = 0;
	int check_count = 0;

	assign bus_in = (ad & ad_oe) | (mem_ad & ~ad_oe);

	always @(posedge clk)
		ipb_rdy <= ipb.sel;

	initial
		forever #12.5 clk = ~clk;

	external_bus_ctrl #(.REF_HALF(RH)) dut
	(
		.i_clk(clk), .i_rst_b(rst_b), .i_single_chip(single_chip),
		.i_addr_width(aw), .i_seg_lines(seg),
		.i_window_address_select(win), .i_region_timing_config(tcfg),
		.i_region_function_config(fcfg),
		.i_default_region_timing_config(dtcfg),
		.i_default_region_function_config(dfcfg),
		.i_req(req), .i_access(acc), .o_busy(busy), .o_ack(ack),
		.o_err(err), .o_rdata(rdata), .o_bus_reference_clock_out(refclk),
		.o_ale(ale), .o_rd_b(rd_b), .o_wr_b(wr_b), .o_cs_b(cs_b),
		.o_addr(addr), .o_addr_oe(addr_oe), .o_ad(ad), .o_ad_oe(ad_oe),
		.i_ad(bus_in), .i_ready(mrdy), .o_internal_peripheral_bus(ipb),
		.i_internal_peripheral_bus_rdata(ipb.addr[15:0] ^ 16'h5A5A),
		.i_internal_peripheral_bus_ready(ipb_rdy)
	);

	ext_mem_model mem_u
	(
		.i_clk(clk), .i_ale(ale), .i_rd_b(rd_b), .i_wr_b(wr_b),
		.i_cs_b(cs_b), .i_addr(addr), .i_ad(ad), .i_muxed(muxed),
		.i_ready_high(rhigh), .i_wait(wt), .o_ad(mem_ad), .o_ready(mrdy)
	);

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic int region_of(input logic [23:0] a);
		if (a[23:12] == 12'h201)
			return 4;
		if (a[23:13] == 11'h100)
			return 3;
		if (a[23:12] == 12'h100)
			return 2;
		if (a[23:13] == 11'h080)
			return 1;
		return 0;
	endfunction : region_of

	task automatic run(input logic we, input logic inl, input logic [23:0] a,
		input logic [15:0] d, output int cyc);
		@(negedge clk);
		acc = {we, inl, a, d};
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		cyc = 1;
		s_cs = ebc_pkg::CS_NONE;
		s_busy = busy;
		while (ack !== 1'b1 && cyc < 3000)
		begin
			if (cs_b !== ebc_pkg::CS_NONE)
				s_cs = cs_b;
			if (ale === 1'b1)
			begin
				s_ad = ad;
				s_addr = addr;
				s_oe = addr_oe;
			end
			@(negedge clk);
			cyc++;
		end
		if (cyc >= 3000)
			fails++;
		s_err = err;
		s_rd = rdata;
	endtask : run

	task automatic xfer(input logic [23:0] a, input logic [15:0] d,
		output int c);
		int r;
		logic [4:0] e;
		ebc_pkg::region_function_config_t f;
		r = region_of(a);
		f = (r == 0) ? dfcfg : fcfg[r - 1];
		e = ~(ebc_pkg::CS_ONE << r);
		muxed = f.muxed;
		rhigh = f.ready_high;
		run(1'b1, 1'b0, a, d, c);
		chk(s_busy, 1'b1);
		chk(busy, 1'b0);
		chk(s_cs, e);
		if (f.muxed)
			chk(s_ad, a[15:0]);
		else
			chk(s_addr[15:0], a[15:0]);
		run(1'b0, 1'b0, a, 16'h0000, c);
		chk(s_err, 1'b0);
		chk(s_rd, f.bus16 ? d : {8'h00, d[7:0]});
	endtask : xfer

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	initial
	begin
		#2000000;
		fails++;
		final_report();
	end

	initial
	begin
		logic [23:0] bases [5];
		logic [23:0] a;
		int c1;
		int c2;
		bases = '{24'h400000, 24'h101000, 24'h100000, 24'h200000, 24'h201000};
		win[0] = {1'b1, 12'h100, 4'h1};
		win[1] = {1'b1, 12'h100, 4'h0};
		win[2] = {1'b1, 12'h200, 4'h1};
		win[3] = {1'b1, 12'h201, 4'h0};
		tcfg[0] = 8'h00;
		tcfg[1] = 8'h00;
		tcfg[2] = 8'h00;
		tcfg[3] = {2'h0, 4'h2, 2'h0};
		fcfg[0] = 5'h09;
		fcfg[1] = 5'h0F;
		fcfg[2] = 5'h15;
		fcfg[3] = 5'h1F;
		void'($urandom(50));
		repeat (5) @(negedge clk);
		chk(cs_b, ebc_pkg::CS_NONE);
		chk(ad_oe, 16'h0000);
		repeat (1) @(negedge clk);
		rst_b = 1'b1;
		repeat (5) @(negedge clk);
		for (int i = 0; i < 40; i++)
		begin
			a = bases[$urandom_range(0, 4)] | 24'($urandom & 32'h0FFF);
			xfer(a, 16'($urandom), c1);
		end
		// Both ready polarities; waiting must add whole reference periods.
		for (int k = 0; k < 2; k++)
		begin
			a = k ? 24'h201040 : 24'h200040;
			wt = 8'h00;
			xfer(a, 16'($urandom), c1);
			wt = 8'h0C;
			xfer(a, 16'($urandom), c2);
			chk(24'(c2 > c1 && (c2 - c1) % (2 * RH) == 0), 24'h000001);
			wt = 8'h00;
		end
		aw = 5'h08;
		xfer(24'h400123, 16'hBEEF, c1);
		chk(s_oe[23:8], 16'h0000);
		aw = 5'h18;
		seg = 3'h0;
		xfer(24'h400124, 16'h1234, c1);
		chk(s_oe[22:16], 7'h00);
		seg = 3'h7;
		xfer(24'h400125, 16'h4321, c1);
		chk(s_oe[22:16], 7'h7F);
		chk(s_oe[15:0], 16'hFFFF);
		single_chip = 1'b1;
		run(1'b1, 1'b0, 24'h400000, 16'h1111, c1);
		chk(s_err, 1'b1);
		chk(s_busy, 1'b0);
		chk(s_cs, ebc_pkg::CS_NONE);
		run(1'b1, 1'b1, 24'h208010, 16'h2222, c1);
		chk(s_err, 1'b0);
		run(1'b0, 1'b1, 24'h208010, 16'h0000, c1);
		chk(s_rd, 16'h8010 ^ 16'h5A5A);
		chk(s_cs, ebc_pkg::CS_NONE);
		single_chip = 1'b0;
		final_report();
	end
endmodule : tb_top

`default_nettype wire
